// file: rtl/drb_consts.svh
`ifndef DRB_CONSTS_SVH
`define DRB_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define DRB_CLK_PS       100000
`define DRB_REFRESH_INTERVAL_AVG_PS     7800000
`define DRB_REFRESH_INTERVAL_AVG_CYC    (`DRB_REFRESH_INTERVAL_AVG_PS / `DRB_CLK_PS)
`define DRB_REFRESH_CYCLE_TIME_PS      160000
`define DRB_REFRESH_CYCLE_TIME_CYC     ((`DRB_REFRESH_CYCLE_TIME_PS + `DRB_CLK_PS - 1) / `DRB_CLK_PS)
`define DRB_TRP_PS       13750
`define DRB_TRP_CYC      ((`DRB_TRP_PS + `DRB_CLK_PS - 1) / `DRB_CLK_PS)
`define DRB_TRCD_PS      13750
`define DRB_TRCD_CYC     ((`DRB_TRCD_PS + `DRB_CLK_PS - 1) / `DRB_CLK_PS)
`define DRB_TMRD_CYC     4
`define DRB_COL_TO_COL_DELAY_CYC     4
`define DRB_BEATS_BL8    8

// ****************************************
// refresh credit limits
// ****************************************
`define DRB_CREDIT_MAX   6'sh08
`define DRB_CREDIT_MIN   6'sh38

// ****************************************
// address fields
// ****************************************
`define DRB_BSEL_BIT     12
`define DRB_AP_BIT       10

// ****************************************
// command pins {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define DRB_CMD_MRS      4'h0
`define DRB_CMD_REF      4'h1
`define DRB_CMD_PRE      4'h2
`define DRB_CMD_ACT      4'h3
`define DRB_CMD_WR       4'h4
`define DRB_CMD_RD       4'h5
`define DRB_CMD_NOP      4'h7

// ****************************************
// mode_reg_zero burst-length field
// ****************************************
`define DRB_BL_FIX8      2'h0
`define DRB_BL_OTF       2'h1
`define DRB_BL_FIX4      2'h2
`define DRB_MR0_RST      2'h0

`endif

// file: rtl/drb_controller.sv
`timescale 1ns/100ps
`include "drb_consts.svh"

// Operation
// RQ1: refresh is chip-select, row, column low, write high
// RQ2: every refresh needs its own command
// RQ3: refreshes average one per interval
// RQ4: all banks precharged, precharge period elapsed first
// RQ5: device takes refresh row from internal counter
// RQ6: refresh completion leaves all banks idle
// RQ7: only idle commands during refresh cycle time
// RQ8: at most eight refreshes deferred
// RQ9: at most eight refreshes pulled in
// RQ10: deferred refreshes done before self-refresh
// RQ11: select bit picks chop four or eight
// RQ12: select bit never part of column
// RQ13: burst select same with auto-precharge
// RQ14: field 00/01 plus bit high gives eight
// RQ15: reinitialise device after timing violation
// RQ16: data timing fault corrupts only that location
// RQ17: strobe timing fault corrupts only that location
// RQ18: every strobe edge of burst meets timing
// RQ19: signed credit counter bounded to eight

module drb_controller
   import drb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   drb_if.ctl               link,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_write,
   input  wire logic [2:0]  req_bank,
   input  wire logic [14:0] req_row,
   input  wire logic [9:0]  req_col,
   input  wire logic        req_burst8,
   input  wire logic        req_autopre,
   input  wire logic [63:0] req_wdata,
   output logic [63:0]      rd_data,
   output logic             rd_valid,
   input  wire logic        pull_in,
   input  wire logic        sr_req,
   output logic             sr_ready,
   input  wire logic        reinit_req,
   output logic             init_done,
   output logic [4:0]       credit
);

   drb_state_type      state_r;
   logic [3:0]         cmd_r;
   logic [2:0]         ba_r;
   logic [14:0]        addr_r;
   logic [3:0]         wait_r;
   logic [3:0]         cyc_r;
   logic               wr_r;
   logic               b8_r;
   logic               ap_r;
   logic [9:0]         col_r;
   logic [63:0]        wdata_r;
   logic [3:0]         beats;
   logic [3:0]         last;
   logic signed [4:0]  credit_r;
   logic signed [5:0]  credit6;
   logic signed [5:0]  csum;
   logic [6:0]         refi_cnt_r;
   logic               tick;
   logic               ref_go;
   logic               ref_issue;
   logic               in_idle;
   logic               init_done_r;
   logic [7:0]         dq_c_r;
   logic               dq_c_oe_r;
   logic [63:0]        rd_data_r;
   logic               rd_valid_r;
   logic [2:0]         rd_idx;
   logic [2:0]         wr_idx;

   assign in_idle   = (state_r == ST_IDLE);
   assign credit6   = {credit_r[4], credit_r};
   assign beats     = b8_r ? 4'(`DRB_BEATS_BL8) : 4'(`DRB_COL_TO_COL_DELAY_CYC); // RQ11
   assign last      = wr_r ? (beats + 4'h1) : (beats + 4'h2);
   assign rd_idx    = 3'(cyc_r - 4'h3);
   assign wr_idx    = 3'(cyc_r - 4'h1);
   assign tick      = (refi_cnt_r == 7'(`DRB_REFRESH_INTERVAL_AVG_CYC - 1));

   // ****************************************
   // refresh scheduling
   // ****************************************
   always_comb begin
      ref_go = 1'b0;
      if (credit6 <= `DRB_CREDIT_MIN) begin
         ref_go = 1'b1; // RQ8
      end else if ((credit6 < 6'sh00) && (!req_valid || sr_req)) begin
         ref_go = 1'b1; // RQ10
      end else if (pull_in && (credit6 < `DRB_CREDIT_MAX) && !req_valid && !sr_req) begin
         ref_go = 1'b1; // RQ9
      end
   end

   assign ref_issue = in_idle && !reinit_req && ref_go;
   assign req_ready = in_idle && !reinit_req && !ref_go && !sr_req;
   assign sr_ready  = in_idle && sr_req && (credit6 >= 6'sh00); // RQ10

   always_comb begin
      csum = credit6;
      if (tick) begin
         csum = csum - 6'sh01; // RQ3
      end
      if (ref_issue) begin
         csum = csum + 6'sh01; // RQ2
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         refi_cnt_r <= 7'h00;
      end else if (tick) begin
         refi_cnt_r <= 7'h00;
      end else begin
         refi_cnt_r <= refi_cnt_r + 7'h01;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         credit_r <= 5'sh00;
      end else if (csum > `DRB_CREDIT_MAX) begin
         credit_r <= 5'(`DRB_CREDIT_MAX); // RQ9 RQ19
      end else if (csum < `DRB_CREDIT_MIN) begin
         credit_r <= 5'(`DRB_CREDIT_MIN); // RQ19
      end else begin
         credit_r <= 5'(csum); // RQ19
      end
   end

   // ****************************************
   // command sequencer
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r <= ST_INIT;
         cmd_r   <= `DRB_CMD_NOP;
         ba_r    <= 3'h0;
         addr_r  <= 15'h0000;
         wait_r  <= 4'h0;
         cyc_r   <= 4'h0;
         wr_r    <= 1'b0;
         b8_r    <= 1'b0;
         ap_r    <= 1'b0;
         col_r   <= 10'h000;
         wdata_r <= 64'h0;
      end else begin
         cmd_r <= `DRB_CMD_NOP;
         case (state_r)
            ST_INIT: begin
               cmd_r   <= `DRB_CMD_MRS;
               ba_r    <= 3'h0;
               addr_r  <= {13'h0000, `DRB_BL_OTF};
               wait_r  <= 4'(`DRB_TMRD_CYC - 1);
               state_r <= ST_WAIT;
            end
            ST_IDLE: begin
               if (reinit_req) begin
                  state_r <= ST_INIT; // RQ15
               end else if (ref_go) begin
                  cmd_r   <= `DRB_CMD_REF; // RQ1 RQ4
                  wait_r  <= 4'(`DRB_REFRESH_CYCLE_TIME_CYC - 1); // RQ7
                  state_r <= ST_WAIT;
               end else if (req_valid && req_ready) begin
                  cmd_r   <= `DRB_CMD_ACT;
                  ba_r    <= req_bank;
                  addr_r  <= req_row;
                  wr_r    <= req_write;
                  b8_r    <= req_burst8;
                  ap_r    <= req_autopre;
                  col_r   <= req_col;
                  wdata_r <= req_wdata;
                  wait_r  <= 4'(`DRB_TRCD_CYC - 1);
                  state_r <= ST_ACT_WAIT;
               end
            end
            ST_ACT_WAIT: begin
               if (wait_r == 4'h0) begin
                  cmd_r                <= wr_r ? `DRB_CMD_WR : `DRB_CMD_RD;
                  addr_r               <= {5'h00, col_r[9:3], 3'h0};
                  addr_r[`DRB_AP_BIT]  <= ap_r; // RQ13
                  addr_r[`DRB_BSEL_BIT] <= b8_r; // RQ11 RQ12
                  cyc_r                <= 4'h1;
                  state_r              <= ST_BURST;
               end else begin
                  wait_r <= wait_r - 4'h1;
               end
            end
            ST_BURST: begin
               cyc_r <= cyc_r + 4'h1;
               if (cyc_r == last) begin
                  if (!ap_r) begin
                     cmd_r  <= `DRB_CMD_PRE;
                     addr_r <= 15'h0000;
                  end
                  wait_r  <= 4'(`DRB_TRP_CYC - 1); // RQ4
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (wait_r == 4'h0) begin
                  state_r <= ST_IDLE;
               end else begin
                  wait_r <= wait_r - 4'h1; // RQ7
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         init_done_r <= 1'b0;
      end else if (state_r == ST_INIT) begin
         init_done_r <= 1'b0;
      end else if (in_idle) begin
         init_done_r <= 1'b1;
      end
   end

   // ****************************************
   // write data and strobe
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dq_c_r    <= 8'h00;
         dq_c_oe_r <= 1'b0;
      end else if ((state_r == ST_BURST) && wr_r && (cyc_r <= beats)) begin
         dq_c_r    <= wdata_r[{wr_idx, 3'h0} +: 8];
         dq_c_oe_r <= 1'b1; // RQ18
      end else begin
         dq_c_oe_r <= 1'b0;
      end
   end

   // ****************************************
   // read capture
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data_r  <= 64'h0;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= (state_r == ST_BURST) && !wr_r && (cyc_r == last);
         if (state_r == ST_ACT_WAIT) begin
            rd_data_r <= 64'h0;
         end else if ((state_r == ST_BURST) && !wr_r && link.dq_d_oe) begin
            rd_data_r[{rd_idx, 3'h0} +: 8] <= link.dq;
         end
      end
   end

   assign link.cs_n     = cmd_r[3];
   assign link.ras_n    = cmd_r[2];
   assign link.cas_n    = cmd_r[1];
   assign link.we_n     = cmd_r[0];
   assign link.ba       = ba_r;
   assign link.addr     = addr_r;
   assign link.dq_c     = dq_c_r;
   assign link.dq_c_oe  = dq_c_oe_r;
   assign link.dqs_c    = dq_c_oe_r; // RQ18
   assign link.dqs_c_oe = dq_c_oe_r;
   assign rd_data       = rd_data_r;
   assign rd_valid      = rd_valid_r;
   assign init_done     = init_done_r;
   assign credit        = credit_r;

endmodule // drb_controller

// file: rtl/drb_device.sv
`timescale 1ns/100ps
`include "drb_consts.svh"

module drb_device
   import drb_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   drb_if.dev               link,
   output logic [14:0]      refresh_row,
   output logic             refresh_busy,
   output logic             write_fault,
   output logic [7:0]       bank_open
);

   drb_cmd_type cmd;
   logic [3:0]  rfc_r;
   logic        cmd_ok;
   logic        is_ref;
   logic        is_rw;
   logic        rfc_done;
   logic [14:0] refresh_row_r;
   logic [7:0]  bank_open_r;
   logic [3:0]  row_r [0:7];
   logic [1:0]  mr0_bl_r;
   logic        bl8;
   logic [3:0]  burst_cnt_r;
   logic [2:0]  beat_r;
   logic        wr_r;
   logic [10:0] base_r;
   logic        ap_r;
   logic [2:0]  ap_bank_r;
   logic        active;
   logic        ap_close;
   logic        beat_good;
   logic        bad_seen_r;
   logic        write_fault_r;
   logic [7:0]  dq_d_r;
   logic        dq_d_oe_r;
   logic [7:0]  storage [0:16383];

   assign cmd       = drb_decode({link.cs_n, link.ras_n, link.cas_n, link.we_n});
   assign cmd_ok    = (rfc_r == 4'h0);
   assign is_ref    = cmd_ok && (cmd == CMD_REF) && (bank_open_r == 8'h00);
   assign is_rw     = cmd_ok && ((cmd == CMD_RD) || (cmd == CMD_WR)) && bank_open_r[link.ba] && !active;
   assign rfc_done  = (rfc_r == 4'h1);
   assign active    = (burst_cnt_r != 4'h0);
   assign ap_close  = (burst_cnt_r == 4'h1) && ap_r;
   assign bl8       = (mr0_bl_r == `DRB_BL_FIX8) || ((mr0_bl_r == `DRB_BL_OTF) && link.addr[`DRB_BSEL_BIT]); // RQ14 RQ11
   assign beat_good = link.dqs_c_oe && link.dqs_c && link.dq_c_oe; // RQ16 RQ17

   // ****************************************
   // refresh cycle
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rfc_r         <= 4'h0;
         refresh_row_r <= 15'h0000;
      end else if (is_ref) begin
         rfc_r         <= 4'(`DRB_REFRESH_CYCLE_TIME_CYC);
         refresh_row_r <= refresh_row_r + 15'h0001; // RQ5
      end else if (rfc_r != 4'h0) begin
         rfc_r         <= rfc_r - 4'h1;
      end
   end

   // ****************************************
   // bank state
   // ****************************************
   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1) begin : g_bank
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               bank_open_r[b] <= 1'b0;
               row_r[b]       <= 4'h0;
            end else if (rfc_done) begin
               bank_open_r[b] <= 1'b0; // RQ6
            end else if (cmd_ok && (cmd == CMD_ACT) && (link.ba == 3'(b))) begin
               bank_open_r[b] <= 1'b1;
               row_r[b]       <= link.addr[3:0];
            end else if (cmd_ok && (cmd == CMD_PRE) && ((link.ba == 3'(b)) || link.addr[`DRB_AP_BIT])) begin
               bank_open_r[b] <= 1'b0;
            end else if (ap_close && (ap_bank_r == 3'(b))) begin
               bank_open_r[b] <= 1'b0; // RQ13
            end
         end
      end
   endgenerate

   // ****************************************
   // mode register
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mr0_bl_r <= `DRB_MR0_RST;
      end else if (cmd_ok && (cmd == CMD_MRS) && (link.ba == 3'h0)) begin
         mr0_bl_r <= link.addr[1:0];
      end
   end

   // ****************************************
   // burst sequencing
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         burst_cnt_r <= 4'h0;
         beat_r      <= 3'h0;
         wr_r        <= 1'b0;
         base_r      <= 11'h000;
         ap_r        <= 1'b0;
         ap_bank_r   <= 3'h0;
      end else if (is_rw) begin
         burst_cnt_r <= bl8 ? 4'(`DRB_BEATS_BL8) : 4'(`DRB_COL_TO_COL_DELAY_CYC); // RQ11
         beat_r      <= 3'h0;
         wr_r        <= (cmd == CMD_WR);
         base_r      <= {link.ba, row_r[link.ba], link.addr[6:3]}; // RQ12
         ap_r        <= link.addr[`DRB_AP_BIT]; // RQ13
         ap_bank_r   <= link.ba;
      end else if (active) begin
         burst_cnt_r <= burst_cnt_r - 4'h1;
         beat_r      <= beat_r + 3'h1;
      end
   end

   // ****************************************
   // storage and data pins
   // ****************************************
   always_ff @(posedge clock) begin
      if (active && wr_r && beat_good) begin
         storage[{base_r, beat_r}] <= link.dq; // RQ16 RQ17
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dq_d_r    <= 8'h00;
         dq_d_oe_r <= 1'b0;
      end else begin
         dq_d_oe_r <= active && !wr_r;
         if (active && !wr_r) begin
            dq_d_r <= storage[{base_r, beat_r}];
         end
      end
   end

   // ****************************************
   // write strobe fault report
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bad_seen_r    <= 1'b0;
         write_fault_r <= 1'b0;
      end else begin
         write_fault_r <= active && wr_r && (burst_cnt_r == 4'h1) && (bad_seen_r || !beat_good); // RQ17
         if (is_rw) begin
            bad_seen_r <= 1'b0;
         end else if (active && wr_r && !beat_good) begin
            bad_seen_r <= 1'b1; // RQ16
         end
      end
   end

   assign link.dq_d    = dq_d_r;
   assign link.dq_d_oe = dq_d_oe_r;
   assign refresh_row  = refresh_row_r;
   assign refresh_busy = !cmd_ok;
   assign write_fault  = write_fault_r;
   assign bank_open    = bank_open_r;

endmodule // drb_device

// file: rtl/drb_if.sv
`timescale 1ns/100ps

interface drb_if (
   input wire logic clock
);
   logic        cs_n;
   logic        ras_n;
   logic        cas_n;
   logic        we_n;
   logic [2:0]  ba;
   logic [14:0] addr;
   logic [7:0]  dq_c;
   logic        dq_c_oe;
   logic        dqs_c;
   logic        dqs_c_oe;
   logic [7:0]  dq_d;
   logic        dq_d_oe;
   logic [7:0]  dq;

   // ****************************************
   // resolved data wire
   // ****************************************
   assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : 8'h00);

   modport ctl (
      output cs_n, ras_n, cas_n, we_n, ba, addr, dq_c, dq_c_oe, dqs_c, dqs_c_oe,
      input  dq, dq_d_oe
   );

   modport dev (
      input  cs_n, ras_n, cas_n, we_n, ba, addr, dq, dq_c_oe, dqs_c, dqs_c_oe,
      output dq_d, dq_d_oe
   );
endinterface

// file: rtl/drb_pkg.sv
`include "drb_consts.svh"

package drb_pkg;

   typedef enum logic [2:0] {CMD_NOP, CMD_REF, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_MRS, CMD_DES} drb_cmd_type;

   typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_ACT_WAIT, ST_BURST, ST_WAIT} drb_state_type;

   function automatic drb_cmd_type drb_decode(input logic [3:0] pins);
      drb_cmd_type c;
      c = CMD_NOP;
      if (pins[3]) begin
         c = CMD_DES;
      end else begin
         case (pins)
            `DRB_CMD_MRS: c = CMD_MRS;
            `DRB_CMD_REF: c = CMD_REF;
            `DRB_CMD_PRE: c = CMD_PRE;
            `DRB_CMD_ACT: c = CMD_ACT;
            `DRB_CMD_WR:  c = CMD_WR;
            `DRB_CMD_RD:  c = CMD_RD;
            default:      c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

endpackage

// file: verif/drb_checker.sv
`timescale 1ns/100ps
`include "drb_consts.svh"

module drb_checker (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        cs_n,
   input wire logic        ras_n,
   input wire logic        cas_n,
   input wire logic        we_n,
   input wire logic [14:0] addr,
   input wire logic        dq_c_oe,
   input wire logic        dqs_c,
   input wire logic        dqs_c_oe,
   input wire logic        dq_d_oe
);
   logic [3:0] cmd;
   logic       stb_ok;
   logic       is_col;

   assign cmd    = {cs_n, ras_n, cas_n, we_n};
   assign stb_ok = dq_c_oe & dqs_c & dqs_c_oe;
   assign is_col = (cmd == `DRB_CMD_RD) || (cmd == `DRB_CMD_WR);

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   property p_ref_recovery;
      cmd == `DRB_CMD_REF |=> (cs_n || cmd == `DRB_CMD_NOP) [*2];
   endproperty
   a_ref_recovery: assert property (p_ref_recovery) else $error("command inside refresh recovery");

   property p_ref_idle;
      cmd == `DRB_CMD_REF |-> !dq_c_oe && !dq_d_oe && $past(cmd) != `DRB_CMD_ACT;
   endproperty
   a_ref_idle: assert property (p_ref_idle) else $error("refresh with bank busy");

   property p_wr_eight;
      cmd == `DRB_CMD_WR && addr[`DRB_BSEL_BIT] |=> stb_ok [*8] ##1 !dq_c_oe;
   endproperty
   a_wr_eight: assert property (p_wr_eight) else $error("write burst of eight wrong");

   property p_wr_four;
      cmd == `DRB_CMD_WR && !addr[`DRB_BSEL_BIT] |=> stb_ok [*4] ##1 !dq_c_oe;
   endproperty
   a_wr_four: assert property (p_wr_four) else $error("write chop of four wrong");

   property p_rd_eight;
      cmd == `DRB_CMD_RD && addr[`DRB_BSEL_BIT] |-> ##2 dq_d_oe [*8] ##1 !dq_d_oe;
   endproperty
   a_rd_eight: assert property (p_rd_eight) else $error("read burst of eight wrong");

   property p_rd_four;
      cmd == `DRB_CMD_RD && !addr[`DRB_BSEL_BIT] |-> ##2 dq_d_oe [*4] ##1 !dq_d_oe;
   endproperty
   a_rd_four: assert property (p_rd_four) else $error("read chop of four wrong");

   property p_col_spacing;
      is_col |=> !is_col [*3];
   endproperty
   a_col_spacing: assert property (p_col_spacing) else $error("column commands too close");

   property p_strobe_cause;
      $rose(dq_c_oe) |-> $past(cmd) == `DRB_CMD_WR;
   endproperty
   a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without write");

endmodule // drb_checker

// file: verif/test_dram_refresh_burst_rules.sv
`timescale 1ns/100ps
`include "drb_consts.svh"

module test_dram_refresh_burst_rules
   import drb_pkg::*;
;
   logic        clock, rst, req_valid, req_ready, req_write, req_burst8, req_autopre, rd_valid;
   logic        pull_in, sr_req, sr_ready, reinit_req, init_done, fault2;
   logic [2:0]  req_bank;
   logic [9:0]  req_col;
   logic [14:0] req_row, refresh_row;
   logic [4:0]  credit;
   logic [7:0]  bank_open;
   logic [63:0] req_wdata, rd_data;
   int          bad_count, num_checks, ref_cnt, mrs_cnt, fault_cnt, cyc, gap, max_gap, cr_min, cr_max;

   drb_if link_a (.clock(clock));
   drb_if link_b (.clock(clock));

   drb_controller drb_controller_i (.clock(clock), .rst(rst), .link(link_a), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
      .req_burst8(req_burst8), .req_autopre(req_autopre), .req_wdata(req_wdata), .rd_data(rd_data),
      .rd_valid(rd_valid), .pull_in(pull_in), .sr_req(sr_req), .sr_ready(sr_ready), .reinit_req(reinit_req),
      .init_done(init_done), .credit(credit));
   drb_device drb_device_i (.clock(clock), .rst(rst), .link(link_a), .refresh_row(refresh_row),
      .refresh_busy(), .write_fault(), .bank_open(bank_open));
   drb_device drb_device_x_i (.clock(clock), .rst(rst), .link(link_b), .refresh_row(), .refresh_busy(),
      .write_fault(fault2), .bank_open());
   drb_checker drb_checker_i (.clock(clock), .rst(rst), .cs_n(link_a.cs_n), .ras_n(link_a.ras_n),
      .cas_n(link_a.cas_n), .we_n(link_a.we_n), .addr(link_a.addr), .dq_c_oe(link_a.dq_c_oe),
      .dqs_c(link_a.dqs_c), .dqs_c_oe(link_a.dqs_c_oe), .dq_d_oe(link_a.dq_d_oe));

   // ****************************************
   // clock, monitor and timeout
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cyc++;
      if (!rst) begin
         gap++;
         if ({link_a.cs_n, link_a.ras_n, link_a.cas_n, link_a.we_n} == `DRB_CMD_REF) begin
            ref_cnt++;
            max_gap = (gap > max_gap) ? gap : max_gap;
            gap = 0;
         end
         if ({link_a.cs_n, link_a.ras_n, link_a.cas_n, link_a.we_n} == `DRB_CMD_MRS) mrs_cnt++;
         if (fault2 === 1'b1) fault_cnt++;
         cr_min = ($signed(credit) < cr_min) ? $signed(credit) : cr_min;
         cr_max = ($signed(credit) > cr_max) ? $signed(credit) : cr_max;
      end
      if (cyc == 8000) begin
         err("timeout");
         summarize();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic err(input string m);
      bad_count++;
      $display("ERROR %0t %s", $time, m);
   endtask

   function automatic logic fail(input logic ok);
      num_checks++;
      return ok !== 1'b1;
   endfunction

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wait_hi(ref logic s, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (s !== 1'b1 && n < lim);
      if (s !== 1'b1) err("no handshake");
   endtask

   task automatic access(input logic wr, input logic [9:0] col, input logic b8, input logic ap,
                         input logic [63:0] d);
      req_valid   <= 1'b1;
      req_write   <= wr;
      req_bank    <= 3'h2;
      req_row     <= 15'h0005;
      req_col     <= col;
      req_burst8  <= b8;
      req_autopre <= ap;
      req_wdata   <= d;
      wait_hi(req_ready, 2000);
      @(posedge clock);
      req_valid <= 1'b0;
      if (!wr) wait_hi(rd_valid, 40);
      @(posedge clock);
   endtask

   task automatic l2(input logic [3:0] c, input logic [14:0] a, input logic oe, input logic stb,
                     input logic [7:0] d);
      {link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} <= c;
      link_b.addr     <= a;
      link_b.dq_c_oe  <= oe;
      link_b.dqs_c_oe <= oe;
      link_b.dqs_c    <= stb;
      link_b.dq_c     <= d;
      @(posedge clock);
   endtask

   function automatic logic [63:0] pat(input int k);
      return 64'h0706050403020100 + 64'(k) * 64'h1010101010101010;
   endfunction

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_rw();
      for (int k = 0; k < 4; k++) begin
         access(1'b1, 10'(k * 8), k[0], k[1], pat(k));
         access(1'b0, 10'(k * 8), k[0], k[1], 64'h0);
         if (fail(rd_data === (k[0] ? pat(k) : {32'h0, pat(k) >> 0} & 64'hffffffff))) err("read data");
      end
   endtask

   task automatic t_idle_refresh();
      int r0;
      r0 = ref_cnt;
      repeat (10 * `DRB_REFRESH_INTERVAL_AVG_CYC) @(posedge clock);
      if (fail(ref_cnt - r0 >= 9 && ref_cnt - r0 <= 11)) err("refresh rate");
      @(negedge clock);
      if (fail(refresh_row === 15'(ref_cnt))) err("refresh row count");
      if (fail(bank_open === 8'h00)) err("banks left open");
   endtask

   task automatic t_postpone();
      max_gap = 0;
      cr_min = 0;
      @(posedge clock);
      req_valid <= 1'b1;
      repeat (900) @(posedge clock);
      req_valid <= 1'b0;
      if (fail(cr_min >= -8 && cr_min < -1)) err("postponed refresh count");
      if (fail(max_gap <= 9 * `DRB_REFRESH_INTERVAL_AVG_CYC)) err("refresh gap too long");
      sr_req <= 1'b1;
      wait_hi(sr_ready, 400);
      if (fail($signed(credit) >= 0)) err("owed refresh before self-refresh");
      @(posedge clock);
      sr_req <= 1'b0;
   endtask

   task automatic t_pull_in();
      cr_max = -16;
      pull_in <= 1'b1;
      repeat (300) @(posedge clock);
      pull_in <= 1'b0;
      if (fail(cr_max == 8)) err("pull-in credit");
   endtask

   task automatic t_write_fault();
      logic [7:0] got[$];
      l2(`DRB_CMD_ACT, 15'h0000, 1'b0, 1'b0, 8'h00);
      for (int w = 0; w < 2; w++) begin
         l2(`DRB_CMD_WR, 15'h1000, 1'b0, 1'b0, 8'h00);
         for (int j = 0; j < 8; j++) l2(`DRB_CMD_NOP, 15'h0, 1'b1, !(w == 1 && j == 3), 8'(w * 16 + j) | 8'ha0);
         repeat (4) l2(`DRB_CMD_NOP, 15'h0, 1'b0, 1'b0, 8'h00);
      end
      if (fail(fault_cnt == 1)) err("write fault flag");
      l2(`DRB_CMD_RD, 15'h1000, 1'b0, 1'b0, 8'h00);
      repeat (12) begin
         l2(`DRB_CMD_NOP, 15'h0, 1'b0, 1'b0, 8'h00);
         if (link_b.dq_d_oe === 1'b1) got.push_back(link_b.dq);
      end
      if (fail(got.size() == 8)) err("read beat count");
      for (int j = 0; j < got.size(); j++)
         if (fail(got[j] === ((j == 3) ? 8'ha3 : (8'hb0 + 8'(j))))) err("write fault data");
   endtask

   task automatic t_reinit();
      int m;
      m = mrs_cnt;
      reinit_req <= 1'b1;
      repeat (60) if (mrs_cnt == m) @(negedge clock);
      @(posedge clock);
      reinit_req <= 1'b0;
      if (fail(mrs_cnt > m)) err("no re-initialisation");
      wait_hi(init_done, 60);
      @(posedge clock);
      access(1'b0, 10'h008, 1'b1, 1'b0, 64'h0);
      if (fail(rd_data === pat(1))) err("read after re-initialisation");
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_bank = 3'h0;
      req_row = 15'h0;
      req_col = 10'h0;
      req_burst8 = 1'b1;
      req_autopre = 1'b0;
      req_wdata = 64'h0;
      pull_in = 1'b0;
      sr_req = 1'b0;
      reinit_req = 1'b0;
      link_b.ba = 3'h0;
      l2(`DRB_CMD_NOP, 15'h0, 1'b0, 1'b0, 8'h00);
      repeat (19) @(posedge clock);
      rst <= 1'b0;
      wait_hi(init_done, 40);
      @(posedge clock);
      t_rw();
      t_idle_refresh();
      t_postpone();
      t_pull_in();
      t_write_fault();
      t_reinit();
      summarize();
   end

endmodule // test_dram_refresh_burst_rules
